// File: src/iprg_pkg.sv
// Package with register map, field layout and reset values of the bank
package iprg_pkg;

  // ----------------------------------------------------------------------
  // Bus and register geometry
  // ----------------------------------------------------------------------
  localparam int unsigned APB_AW = 12;
  localparam int unsigned REG_W = 16;
  localparam int unsigned FIELD_W = 3;
  localparam int unsigned NUM_SRC = 19;

  // ----------------------------------------------------------------------
  // Byte offsets of the registers
  // ----------------------------------------------------------------------
  localparam logic [11:0] OFF_PRIO3 = 12'h000;
  localparam logic [11:0] OFF_PRIO4 = 12'h004;
  localparam logic [11:0] OFF_PRIO5 = 12'h008;
  localparam logic [11:0] OFF_PRIO6 = 12'h00C;
  localparam logic [11:0] OFF_PRIO7 = 12'h010;
  localparam logic [11:0] OFF_REQ_STAT = 12'h014;
  localparam logic [11:0] OFF_LVL_STAT = 12'h018;

  // ----------------------------------------------------------------------
  // Field positions (least significant bit of each 3-bit field)
  // ----------------------------------------------------------------------
  localparam int unsigned FLD_HI = 12;
  localparam int unsigned FLD_MH = 8;
  localparam int unsigned FLD_ML = 4;
  localparam int unsigned FLD_LO = 0;

  // ----------------------------------------------------------------------
  // Implemented bits and power-on values
  // ----------------------------------------------------------------------
  localparam logic [15:0] MASK_FULL = 16'h7777;
  localparam logic [15:0] MASK_PRIO5 = 16'h7707;
  localparam logic [15:0] RST_FULL = 16'h4444;
  localparam logic [15:0] RST_PRIO5 = 16'h4404;

  // ----------------------------------------------------------------------
  // Priority codes
  // ----------------------------------------------------------------------
  localparam logic [2:0] PRIO_OFF = 3'h0;
  localparam logic [2:0] PRIO_MIN = 3'h1;
  localparam logic [2:0] PRIO_MAX = 3'h7;

  // ----------------------------------------------------------------------
  // Status register layout
  // ----------------------------------------------------------------------
  localparam int unsigned LVL_ANY_BIT = 3;

endpackage

// File: src/iprg_prio_reg.sv
// One 16-bit priority register with implemented-bit mask and byte lanes
`timescale 1ns/1ps
`default_nettype none

module iprg_prio_reg #(
  parameter logic [15:0] IMPL_MASK = iprg_pkg::MASK_FULL,
  parameter logic [15:0] RST_VAL = iprg_pkg::RST_FULL
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_en,
  input wire logic [1:0] byte_en,
  input wire logic [15:0] wdata,
  output logic [15:0] value_q
);

  // ----------------------------------------------------------------------
  // Next value
  // ----------------------------------------------------------------------
  logic [15:0] lane_mask;
  logic [15:0] value_d;

  // Each enabled lane takes write data, only on implemented bits
  assign lane_mask = {{8{byte_en[1]}}, {8{byte_en[0]}}} & IMPL_MASK;
  assign value_d = wr_en ?
    ((value_q & ~lane_mask) | (wdata & lane_mask)) : value_q;

  // Unimplemented bits are never set, so they always read back zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value_q <= RST_VAL;
    end else begin
      value_q <= value_d & IMPL_MASK;
    end
  end

endmodule

`default_nettype wire

// File: src/iprg_top.sv
// APB register bank holding priority fields for nineteen interrupt sources
//
// What this block does
// - Code seven is top priority level
// - Code one is lowest active level
// - Code zero disables the source completely
// - Fields reset to level four
// - Unimplemented bits read back zero
// - Fields at 14-12, 10-8, 6-4, 2-0
// - Third register: flash, DMA1, ADC, UART1 transmit
// - Fourth register: change, comparator, I2C1 master/slave
// - Fifth register: capcmp6, capcmp5, external interrupt one
// - Sixth register: timer4, outcmp4, outcmp3, DMA2
// - Seventh register: UART2 tx/rx, ext irq2, timer5
`timescale 1ns/1ps
`default_nettype none

module iprg_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [18:0] src_flag,
  output logic [2:0] flash_prog_prio,
  output logic [2:0] dma_ch1_prio,
  output logic [2:0] adc_prio,
  output logic [2:0] uart1_tx_prio,
  output logic [2:0] change_notify_prio,
  output logic [2:0] comparator_prio,
  output logic [2:0] i2c1_master_prio,
  output logic [2:0] i2c1_slave_prio,
  output logic [2:0] capcmp6_prio,
  output logic [2:0] capcmp5_prio,
  output logic [2:0] ext_irq1_prio,
  output logic [2:0] timer4_prio,
  output logic [2:0] outcmp4_prio,
  output logic [2:0] outcmp3_prio,
  output logic [2:0] dma_ch2_prio,
  output logic [2:0] uart2_tx_prio,
  output logic [2:0] uart2_rx_prio,
  output logic [2:0] ext_irq2_prio,
  output logic [2:0] timer5_prio,
  output logic [18:0] src_req,
  output logic [2:0] req_level,
  output logic req_any
);

  // ----------------------------------------------------------------------
  // Bus phase decode
  // ----------------------------------------------------------------------
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic access_ph;
  logic done;
  logic wr_done;

  // One wait state: pready rises in the second access cycle. A master that
  // kept penable high past pready would be answered again two cycles later,
  // so every transfer must start with its own setup cycle
  assign access_ph = psel & penable;
  assign pready_d = access_ph & ~pready_q;
  assign done = access_ph & pready_q;
  assign wr_done = done & pwrite;

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  logic hit3;
  logic hit4;
  logic hit5;
  logic hit6;
  logic hit7;
  logic hit_req;
  logic hit_lvl;
  logic hit_any;

  // Word aligned compare against each mapped offset
  // The full address is compared, so a misaligned access hits nothing
  assign hit3 = (paddr == iprg_pkg::OFF_PRIO3);
  assign hit4 = (paddr == iprg_pkg::OFF_PRIO4);
  assign hit5 = (paddr == iprg_pkg::OFF_PRIO5);
  assign hit6 = (paddr == iprg_pkg::OFF_PRIO6);
  assign hit7 = (paddr == iprg_pkg::OFF_PRIO7);
  assign hit_req = (paddr == iprg_pkg::OFF_REQ_STAT);
  assign hit_lvl = (paddr == iprg_pkg::OFF_LVL_STAT);
  assign hit_any = hit3 | hit4 | hit5 | hit6 | hit7 | hit_req | hit_lvl;

  // ----------------------------------------------------------------------
  // Priority registers
  // ----------------------------------------------------------------------
  logic [15:0] prio3_q;
  logic [15:0] prio4_q;
  logic [15:0] prio5_q;
  logic [15:0] prio6_q;
  logic [15:0] prio7_q;
  logic [1:0] lanes;
  logic we3;
  logic we4;
  logic we5;
  logic we6;
  logic we7;

  // Only the two low byte lanes reach the 16-bit registers
  assign lanes = pstrb[1:0];

  // A write lands only at the edge that ends the access phase, so a
  // refused or still waiting transfer never disturbs a field
  assign we3 = wr_done & hit3;
  assign we4 = wr_done & hit4;
  assign we5 = wr_done & hit5;
  assign we6 = wr_done & hit6;
  assign we7 = wr_done & hit7;

  // Third register: all four fields implemented
  iprg_prio_reg #(
    .IMPL_MASK(iprg_pkg::MASK_FULL),
    .RST_VAL(iprg_pkg::RST_FULL)
  ) u_prio3 (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(we3),
    .byte_en(lanes),
    .wdata(pwdata[15:0]),
    .value_q(prio3_q)
  );

  // Fourth register
  iprg_prio_reg #(
    .IMPL_MASK(iprg_pkg::MASK_FULL),
    .RST_VAL(iprg_pkg::RST_FULL)
  ) u_prio4 (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(we4),
    .byte_en(lanes),
    .wdata(pwdata[15:0]),
    .value_q(prio4_q)
  );

  // Fifth register: bits 7-3 are absent, so the mask drops field 6-4
  iprg_prio_reg #(
    .IMPL_MASK(iprg_pkg::MASK_PRIO5),
    .RST_VAL(iprg_pkg::RST_PRIO5)
  ) u_prio5 (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(we5),
    .byte_en(lanes),
    .wdata(pwdata[15:0]),
    .value_q(prio5_q)
  );

  // Sixth register
  iprg_prio_reg #(
    .IMPL_MASK(iprg_pkg::MASK_FULL),
    .RST_VAL(iprg_pkg::RST_FULL)
  ) u_prio6 (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(we6),
    .byte_en(lanes),
    .wdata(pwdata[15:0]),
    .value_q(prio6_q)
  );

  // Seventh register
  iprg_prio_reg #(
    .IMPL_MASK(iprg_pkg::MASK_FULL),
    .RST_VAL(iprg_pkg::RST_FULL)
  ) u_prio7 (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(we7),
    .byte_en(lanes),
    .wdata(pwdata[15:0]),
    .value_q(prio7_q)
  );

  // ----------------------------------------------------------------------
  // Field extraction, one 3-bit slice per source
  // ----------------------------------------------------------------------
  localparam int unsigned FW = iprg_pkg::FIELD_W;
  localparam int unsigned HI = iprg_pkg::FLD_HI;
  localparam int unsigned MH = iprg_pkg::FLD_MH;
  localparam int unsigned ML = iprg_pkg::FLD_ML;
  localparam int unsigned LO = iprg_pkg::FLD_LO;

  // Third register sources
  assign flash_prog_prio = prio3_q[HI +: FW];
  assign dma_ch1_prio = prio3_q[MH +: FW];
  assign adc_prio = prio3_q[ML +: FW];
  assign uart1_tx_prio = prio3_q[LO +: FW];

  // Fourth register sources
  assign change_notify_prio = prio4_q[HI +: FW];
  assign comparator_prio = prio4_q[MH +: FW];
  assign i2c1_master_prio = prio4_q[ML +: FW];
  assign i2c1_slave_prio = prio4_q[LO +: FW];

  // Fifth register sources; bits 7-3 are absent there, so no source
  // takes a field at 6-4
  assign capcmp6_prio = prio5_q[HI +: FW];
  assign capcmp5_prio = prio5_q[MH +: FW];
  assign ext_irq1_prio = prio5_q[LO +: FW];

  // Sixth register sources
  assign timer4_prio = prio6_q[HI +: FW];
  assign outcmp4_prio = prio6_q[MH +: FW];
  assign outcmp3_prio = prio6_q[ML +: FW];
  assign dma_ch2_prio = prio6_q[LO +: FW];

  // Seventh register sources
  assign uart2_tx_prio = prio7_q[HI +: FW];
  assign uart2_rx_prio = prio7_q[MH +: FW];
  assign ext_irq2_prio = prio7_q[ML +: FW];
  assign timer5_prio = prio7_q[LO +: FW];

  // ----------------------------------------------------------------------
  // Source table, index order matches src_flag and src_req
  // ----------------------------------------------------------------------
  logic [2:0] lvl [19];

  assign lvl[0] = flash_prog_prio;
  assign lvl[1] = dma_ch1_prio;
  assign lvl[2] = adc_prio;
  assign lvl[3] = uart1_tx_prio;
  assign lvl[4] = change_notify_prio;
  assign lvl[5] = comparator_prio;
  assign lvl[6] = i2c1_master_prio;
  assign lvl[7] = i2c1_slave_prio;
  assign lvl[8] = capcmp6_prio;
  assign lvl[9] = capcmp5_prio;
  assign lvl[10] = ext_irq1_prio;
  assign lvl[11] = timer4_prio;
  assign lvl[12] = outcmp4_prio;
  assign lvl[13] = outcmp3_prio;
  assign lvl[14] = dma_ch2_prio;
  assign lvl[15] = uart2_tx_prio;
  assign lvl[16] = uart2_rx_prio;
  assign lvl[17] = ext_irq2_prio;
  assign lvl[18] = timer5_prio;

  // ----------------------------------------------------------------------
  // Request gating and highest pending level
  // ----------------------------------------------------------------------
  logic [18:0] src_req_d;
  logic [18:0] src_req_q;
  logic [2:0] req_level_d;
  logic [2:0] req_level_q;
  logic req_any_q;

  // A zero code blocks the flag whatever its state; the numeric code is
  // the level itself, so plain magnitude compare orders 1 up to 7
  // Equal levels are not ordered here; the arbiter that reads these
  // fields decides which source of one level goes first
  always_comb begin
    src_req_d = '0;
    req_level_d = iprg_pkg::PRIO_OFF;
    for (int i = 0; i < 19; i++) begin
      src_req_d[i] = src_flag[i] & (lvl[i] != iprg_pkg::PRIO_OFF);
      if (src_req_d[i] && (lvl[i] > req_level_d)) begin
        req_level_d = lvl[i];
      end
    end
  end

  // Registered so every output comes from a flop; costs one cycle latency
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_req_q <= '0;
      req_level_q <= iprg_pkg::PRIO_OFF;
      req_any_q <= 1'b0;
    end else begin
      src_req_q <= src_req_d;
      req_level_q <= req_level_d;
      req_any_q <= |src_req_d;
    end
  end

  assign src_req = src_req_q;
  assign req_level = req_level_q;
  assign req_any = req_any_q;

  // ----------------------------------------------------------------------
  // Read data selection
  // ----------------------------------------------------------------------
  logic [31:0] rd_mux;
  logic [31:0] lvl_word;
  logic [31:0] req_word;

  // Level word: bits 2-0 highest level, bit 3 any request pending
  assign lvl_word = {28'h0000000, req_any_q, req_level_q};

  // Request word: one bit per source, same index as src_flag
  assign req_word = {13'h0000, src_req_q};

  // Upper half of every priority word reads zero; unmapped reads zero
  assign rd_mux =
    hit3 ? {16'h0000, prio3_q} :
    hit4 ? {16'h0000, prio4_q} :
    hit5 ? {16'h0000, prio5_q} :
    hit6 ? {16'h0000, prio6_q} :
    hit7 ? {16'h0000, prio7_q} :
    hit_req ? req_word :
    hit_lvl ? lvl_word :
    32'h00000000;

  // ----------------------------------------------------------------------
  // APB response flops
  // ----------------------------------------------------------------------
  // Data and error are loaded with pready so they are stable while it is
  // high; an unmapped address answers with pslverr and changes nothing
  // prdata keeps its last read value after the pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pready_d & ~hit_any;
      if (pready_d && !pwrite) begin
        prdata_q <= rd_mux;
      end
    end
  end

  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;

endmodule

`default_nettype wire

// File: test/iprg_chk_sva.sv
// Port-level checks of the priority register bank
`timescale 1ns/1ps
`default_nettype none

module iprg_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [18:0] src_flag,
  input wire logic [2:0] flash_prog_prio,
  input wire logic [18:0] src_req,
  input wire logic [2:0] req_level,
  input wire logic req_any
);
  // ----
  // Bus, field and request checks
  // ----
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Read strobe and the implemented bits of the addressed register
  wire logic rd = pready && !pwrite;
  wire logic wr0 = pready && pwrite && paddr == iprg_pkg::OFF_PRIO3;
  wire logic [15:0] msk = (paddr == iprg_pkg::OFF_PRIO5) ?
    iprg_pkg::MASK_PRIO5 : iprg_pkg::MASK_FULL;

  chk_ready_wait: assert property (
    $rose(penable) && psel |-> !pready ##1 pready)
    else $error("pready not after one wait state");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_err_map: assert property (pready |->
    pslverr == (paddr[1:0] != 2'b00 || paddr > iprg_pkg::OFF_LVL_STAT))
    else $error("pslverr against address map");
  chk_rd_unimpl: assert property (
    rd && paddr < iprg_pkg::OFF_REQ_STAT |->
    (prdata & ~{16'h0000, msk}) == 32'h0)
    else $error("unimplemented bits read nonzero");
  chk_rd_field: assert property (
    rd && paddr == iprg_pkg::OFF_PRIO3 |-> prdata[14:12] == flash_prog_prio)
    else $error("read field differs from output");
  chk_wr_field: assert property (
    wr0 && pstrb[1] |=> flash_prog_prio == $past(pwdata[14:12]))
    else $error("field write lost");
  chk_wr_hold: assert property (!wr0 |=> $stable(flash_prog_prio))
    else $error("field changed without write");
  chk_req_gate: assert property ($past(presetn) |->
    src_req[0] == ($past(src_flag[0]) && $past(flash_prog_prio) != 3'h0))
    else $error("request not gated by field");
  chk_any_level: assert property (req_any == (req_level != 3'h0))
    else $error("level and any disagree");
  chk_any_or: assert property (req_any == (src_req != 19'h0))
    else $error("any is not the OR of requests");
endmodule

`default_nettype wire

// File: test/testbench.sv
// Self-checking bench of the priority register bank
`timescale 1ns/1ps
`default_nettype none

module testbench;
  // ----
  // Signals, shadow registers, counters
  // ----
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, req_any;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, lf;
  logic [3:0] pstrb;
  logic [18:0] src_flag, src_req, exq;
  logic [2:0] req_level, exl;
  logic [2:0] pr [19];
  logic [15:0] sh [5];
  int miscompares, comparisons;

  iprg_top dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src_flag(src_flag), .flash_prog_prio(pr[0]), .dma_ch1_prio(pr[1]),
    .adc_prio(pr[2]), .uart1_tx_prio(pr[3]), .change_notify_prio(pr[4]),
    .comparator_prio(pr[5]), .i2c1_master_prio(pr[6]),
    .i2c1_slave_prio(pr[7]), .capcmp6_prio(pr[8]), .capcmp5_prio(pr[9]),
    .ext_irq1_prio(pr[10]), .timer4_prio(pr[11]), .outcmp4_prio(pr[12]),
    .outcmp3_prio(pr[13]), .dma_ch2_prio(pr[14]), .uart2_tx_prio(pr[15]),
    .uart2_rx_prio(pr[16]), .ext_irq2_prio(pr[17]), .timer5_prio(pr[18]),
    .src_req(src_req), .req_level(req_level), .req_any(req_any)
  );

  // 200 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Fifth register keeps only its low field below bit 8
  function automatic logic [15:0] msk(int r);
    return (r == 2) ? iprg_pkg::MASK_PRIO5 : iprg_pkg::MASK_FULL;
  endfunction

  // Field of source i as the shadow registers hold it
  function automatic logic [2:0] exf(int i);
    int r, p;
    r = 3 + (i - 11) / 4;
    p = 12 - 4 * ((i - 11) % 4);
    if (i < 8) begin
      r = i / 4;
      p = 12 - 4 * (i % 4);
    end else if (i < 11) begin
      r = 2;
      p = (i == 10) ? 0 : 44 - 4 * i;
    end
    return sh[r][p+:3];
  endfunction

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic print_verdict();
    if (miscompares == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // One transfer; the request stands until pready is sampled high
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d,
                     logic [3:0] s);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      miscompares++;
      print_verdict();
    end
  endtask

  // Only enabled byte lanes and implemented bits reach the shadow
  task automatic wr(int r, logic [31:0] d, logic [3:0] s);
    logic [15:0] m;
    m = {{8{s[1]}}, {8{s[0]}}};
    apb(1'b1, iprg_pkg::OFF_PRIO3 + 12'(4 * r), d, s);
    sh[r] = ((sh[r] & ~m) | (d[15:0] & m)) & msk(r);
    chk("wr_err", er, 32'h0);
  endtask

  task automatic rdchk(int r);
    apb(1'b0, iprg_pkg::OFF_PRIO3 + 12'(4 * r), '0, '0);
    chk("rd_data", rd, {16'h0000, sh[r]});
  endtask

  // Fields, requests and level after writes and flags have settled
  task automatic check_all();
    exq = '0;
    exl = '0;
    repeat (2) @(posedge pclk);
    for (int i = 0; i < 19; i++) begin
      chk("fld", pr[i], exf(i));
      exq[i] = src_flag[i] && exf(i) != 3'h0;
      if (exq[i] && exf(i) > exl) exl = exf(i);
    end
    chk("src_req", src_req, exq);
    chk("level", req_level, exl);
    chk("any", req_any, |exq);
  endtask

  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (int r = 0; r < 5; r++) begin
      sh[r] = (r == 2) ? iprg_pkg::RST_PRIO5 : iprg_pkg::RST_FULL;
    end
  endtask

  // ----
  // Main sequence
  // ----
  initial begin
    int r;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = '0;
    src_flag = '0;
    miscompares = 0;
    comparisons = 0;
    lf = 32'h0000004A;
    do_reset();
    check_all();
    for (int k = 0; k < 5; k++) rdchk(k);
    // Each code on a lone source: zero silences it
    src_flag <= 19'h00001;
    for (int c = 0; c < 8; c++) begin
      wr(0, 32'(c) << 12, 4'h2);
      check_all();
    end
    for (int k = 0; k < 5; k++) wr(k, 32'hFFFFFFFF, 4'hF);
    // Refused addresses and a status register write leave every register untouched
    apb(1'b0, 12'h01C, '0, '0);
    chk("unmapped_err", er, 32'h1);
    chk("unmapped_rd", rd, 32'h0);
    apb(1'b1, 12'h002, 32'h0, 4'hF);
    chk("misaligned_err", er, 32'h1);
    apb(1'b1, iprg_pkg::OFF_REQ_STAT, 32'h0, 4'hF);
    chk("stat_wr_err", er, 32'h0);
    for (int k = 0; k < 5; k++) rdchk(k);
    src_flag <= 19'h7FFFF;
    check_all();
    apb(1'b0, iprg_pkg::OFF_REQ_STAT, '0, '0);
    chk("req_stat", rd, 32'(exq));
    apb(1'b0, iprg_pkg::OFF_LVL_STAT, '0, '0);
    chk("lvl_stat", rd, {28'h0, |exq, exl});
    // Random flags, registers, data and byte lanes
    for (int k = 0; k < 60; k++) begin
      lf = lfsr(lf);
      src_flag <= lf[30:12];
      lf = lfsr(lf);
      r = int'(lf[7:0]) % 5;
      wr(r, lfsr(lf), lf[11:8]);
      rdchk(r);
      check_all();
    end
    // Second reset in mid-run restores level four everywhere
    src_flag <= '0;
    do_reset();
    check_all();
    for (int k = 0; k < 5; k++) rdchk(k);
    print_verdict();
  end
endmodule

bind iprg_top iprg_chk chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .src_flag(src_flag), .flash_prog_prio(flash_prog_prio),
  .src_req(src_req), .req_level(req_level), .req_any(req_any)
);

`default_nettype wire
